// ==== verilog/mp_bus_pkg.sv ====
// Package of shared constants and types for the shared-bus arbitration ends
package mp_bus_pkg;
   localparam int NUM_PROC      = 4;
   localparam int NUM_REQ       = 6;
   localparam int ID_W          = 3;
   localparam int ADDR_W        = 32;
   localparam int DATA_W        = 48;
   localparam int SEL_W         = 4;
   localparam int ACK_WAIT_CYC  = 2;
   localparam logic [ID_W-1:0] ID_NONE = 3'h0;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'h1,
      ST_MASTER = 4'h2,
      ST_HOST   = 4'h4,
      ST_FLOAT  = 4'h8
   } bus_state_t;
endpackage

// ==== verilog/mp_bus_if.sv ====
// Interface joining the processor module end and the host end of the shared bus
`timescale 1ns/10ps
interface mp_bus_if;
   logic                               bus_float_request_b;
   logic                               host_bus_request_b;
   logic                               host_bus_grant_b;
   logic                               host_bus_grant_oe;
   logic [mp_bus_pkg::SEL_W-1:0]       proc_select_b;
   logic                               host_wait_ack_out;
   logic                               host_wait_ack_oe;
   logic [mp_bus_pkg::NUM_REQ-1:0]     mp_bus_request_b;
   logic                               core_priority_access_oe;
   logic                               core_priority_access_b;
   logic                               bus_drive_oe;
   logic [mp_bus_pkg::ADDR_W-1:0]      addr;
   logic                               rd_b;
   logic                               wr_b;

   modport device (
      input  bus_float_request_b,
      input  host_bus_request_b,
      input  host_bus_grant_b,
      output host_bus_grant_oe,
      input  proc_select_b,
      output host_wait_ack_out,
      output host_wait_ack_oe,
      input  mp_bus_request_b,
      output core_priority_access_oe,
      input  core_priority_access_b,
      output bus_drive_oe
   );
   modport host (
      output bus_float_request_b,
      output host_bus_request_b,
      input  host_bus_grant_b,
      output proc_select_b,
      input  host_wait_ack_out,
      input  host_wait_ack_oe,
      output addr,
      output rd_b,
      output wr_b
   );
endinterface

// ==== verilog/mp_bus_device.sv ====
// Processor module end: host grant, wait acknowledge and multiprocessor arbitration
`timescale 1ns/10ps
module mp_bus_device (
   input  wire logic                            core_clk_in,
   input  wire logic                            rst_b_in,
   mp_bus_if.device                             bus,
   input  wire logic [mp_bus_pkg::NUM_PROC-1:0] core_access_req_in,
   input  wire logic [mp_bus_pkg::NUM_PROC-1:0] dma_access_req_in,
   input  wire logic [mp_bus_pkg::NUM_PROC-1:0] ack_drive_mode_in,
   input  wire logic [mp_bus_pkg::ID_W-1:0]     proc_id_base_in,
   input  wire logic                            rotating_priority_select_in,
   input  wire logic                            host_access_done_in,
   output logic [mp_bus_pkg::NUM_PROC-1:0]      access_grant_out,
   output logic [mp_bus_pkg::NUM_PROC-1:0]      access_stall_out,
   output logic [mp_bus_pkg::NUM_REQ-1:0]       mp_bus_request_drive_out,
   output logic [mp_bus_pkg::ID_W-1:0]          bus_master_id_out
);
   mp_bus_pkg::bus_state_t              state;
   logic [mp_bus_pkg::NUM_REQ-1:0]      req_vec;
   logic [mp_bus_pkg::NUM_REQ-1:0]      own_req;
   logic [mp_bus_pkg::ID_W-1:0]         last_id;
   logic [mp_bus_pkg::ID_W-1:0]         next_id;
   logic [mp_bus_pkg::ACK_WAIT_CYC:0]   ack_cnt;
   logic                                any_sel;
   logic                                float_now;
   logic                                host_req;
   logic                                cpa_active;
   logic                                still_req;

   // Request line index of a processor: its id minus one (ids count from one)
   function automatic logic [mp_bus_pkg::ID_W-1:0] line_of(input logic [mp_bus_pkg::ID_W-1:0] id);
      line_of = id - 3'h1;
   endfunction

   // Pick winner from a request vector: fixed favours lowest id, rotating starts past last
   function automatic logic [mp_bus_pkg::ID_W-1:0] pick(
      input logic [mp_bus_pkg::NUM_REQ-1:0] req,
      input logic [mp_bus_pkg::ID_W-1:0]    last,
      input logic                           rot);
      logic [mp_bus_pkg::ID_W-1:0] win;
      logic [mp_bus_pkg::ID_W-1:0] idx;
      win = mp_bus_pkg::ID_NONE;
      for (int k = mp_bus_pkg::NUM_REQ - 1; k >= 0; k--) begin
         if (rot && last != mp_bus_pkg::ID_NONE) begin
            idx = 3'((int'(last) + k) % mp_bus_pkg::NUM_REQ);
         end else begin
            idx = 3'(k);
         end
         if (req[idx]) begin
            win = idx + 3'h1;
         end
      end
      pick = win;
   endfunction

   assign host_req   = !bus.host_bus_request_b;
   assign float_now  = !bus.bus_float_request_b;
   assign any_sel    = !(&bus.proc_select_b);
   assign cpa_active = !bus.core_priority_access_b;

   // Our processors' own lines plus every monitored line from the wider system
   always_comb begin
      own_req = '0;
      for (int p = 0; p < mp_bus_pkg::NUM_PROC; p++) begin
         if (core_access_req_in[p] || (dma_access_req_in[p] && !cpa_active)) begin
            own_req[line_of(proc_id_base_in + 3'(p))] = 1'b1;
         end
      end
      req_vec = own_req | ~bus.mp_bus_request_b;
      next_id = pick(req_vec, last_id, rotating_priority_select_in);
      // Current master keeps the bus for as long as its own line stays asserted
      still_req = 1'b0;
      if (last_id != mp_bus_pkg::ID_NONE) begin
         still_req = req_vec[line_of(last_id)];
      end
   end

   // Arbitration: float beats all, host beats processors, then processors by priority
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         state   <= mp_bus_pkg::ST_IDLE;
         last_id <= mp_bus_pkg::ID_NONE;
      end else begin
         case (state)
            mp_bus_pkg::ST_IDLE, mp_bus_pkg::ST_MASTER: begin
               if (float_now) begin
                  state <= mp_bus_pkg::ST_FLOAT;
               end else if (host_req) begin
                  state <= mp_bus_pkg::ST_HOST;
               end else if (state == mp_bus_pkg::ST_MASTER && still_req) begin
                  // No preemption: the priority scheme only decides at a handover
                  state <= mp_bus_pkg::ST_MASTER;
               end else if (next_id != mp_bus_pkg::ID_NONE) begin
                  state   <= mp_bus_pkg::ST_MASTER;
                  last_id <= next_id;
               end else begin
                  state <= mp_bus_pkg::ST_IDLE;
               end
            end
            mp_bus_pkg::ST_HOST: begin
               if (!host_req) begin
                  state <= mp_bus_pkg::ST_IDLE;
               end
            end
            mp_bus_pkg::ST_FLOAT: begin
               if (!float_now) begin
                  state <= mp_bus_pkg::ST_IDLE;
               end
            end
            default: state <= mp_bus_pkg::ST_IDLE;
         endcase
      end
   end

   // Per-processor grant; processor p carries id base plus p
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         access_grant_out <= '0;
      end else begin
         for (int p = 0; p < mp_bus_pkg::NUM_PROC; p++) begin
            access_grant_out[p] <= (state == mp_bus_pkg::ST_MASTER) && !float_now &&
                                   !host_req && last_id == proc_id_base_in + 3'(p);
         end
      end
   end

   // A processor wanting the bus stalls while it is floated or held by the host
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         access_stall_out <= '0;
      end else begin
         for (int p = 0; p < mp_bus_pkg::NUM_PROC; p++) begin
            access_stall_out[p] <= (core_access_req_in[p] || dma_access_req_in[p]) &&
                                   (float_now || host_req);
         end
      end
   end

   // Bus pins float the cycle after a float request or on handing to the host
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         bus.bus_drive_oe <= 1'b0;
      end else begin
         bus.bus_drive_oe <= (state == mp_bus_pkg::ST_MASTER) && !float_now &&
                             !host_req;
      end
   end

   // Grant stays low while the host holds its request and no float is requested; driven in idle, master or host state
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         bus.host_bus_grant_oe <= 1'b0;
      end else begin
         bus.host_bus_grant_oe <= host_req && !float_now &&
                                  (state == mp_bus_pkg::ST_HOST ||
                                   state == mp_bus_pkg::ST_MASTER ||
                                   state == mp_bus_pkg::ST_IDLE);
      end
   end

   // Wait acknowledge: low for a fixed wait, then high when done; open drain by default
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         ack_cnt                 <= '0;
         bus.host_wait_ack_out   <= 1'b0;
         bus.host_wait_ack_oe    <= 1'b0;
      end else if (any_sel && host_req && state == mp_bus_pkg::ST_HOST) begin
         if (!ack_cnt[mp_bus_pkg::ACK_WAIT_CYC] && !host_access_done_in) begin
            ack_cnt               <= ack_cnt + 1'b1;
            bus.host_wait_ack_out <= 1'b0;
            bus.host_wait_ack_oe  <= 1'b1;
         end else begin
            // Push-pull drives the ready level; open drain just lets go of the line
            bus.host_wait_ack_out <= 1'b1;
            bus.host_wait_ack_oe  <= |(ack_drive_mode_in & ~bus.proc_select_b);
         end
      end else begin
         ack_cnt               <= '0;
         bus.host_wait_ack_out <= 1'b0;
         bus.host_wait_ack_oe  <= 1'b0;
      end
   end

   // Wired core priority line pulled low while any core needs the bus as a slave
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         bus.core_priority_access_oe <= 1'b0;
      end else begin
         bus.core_priority_access_oe <= |core_access_req_in;
      end
   end

   // Request lines this module pulls low, for observation
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         mp_bus_request_drive_out <= '0;
      end else begin
         mp_bus_request_drive_out <= own_req;
      end
   end

   // Id of the current master, zero while nobody or the host holds the bus
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         bus_master_id_out <= mp_bus_pkg::ID_NONE;
      end else begin
         bus_master_id_out <= (state == mp_bus_pkg::ST_MASTER) ? last_id
                                                               : mp_bus_pkg::ID_NONE;
      end
   end
endmodule

// ==== verilog/mp_bus_host.sv ====
// Host end: requests the shared bus, selects one processor and honours wait states
`timescale 1ns/10ps
module mp_bus_host (
   input  wire logic                            core_clk_in,
   input  wire logic                            rst_b_in,
   mp_bus_if.host                               bus,
   input  wire logic                            access_req_in,
   input  wire logic [1:0]                      proc_index_in,
   input  wire logic                            access_write_in,
   input  wire logic [mp_bus_pkg::ADDR_W-1:0]   access_addr_in,
   input  wire logic                            float_req_in,
   output logic                                 access_done_out,
   output logic                                 bus_owned_out
);
   logic ack_level;
   logic granted;
   logic ack_armed;

   // Wired acknowledge: undriven line reads high through its pull-up
   assign ack_level = bus.host_wait_ack_oe ? bus.host_wait_ack_out : 1'b1;
   assign granted   = !bus.host_bus_grant_b;

   // Registered acknowledge lags the select by a cycle, so its first cycle is not trusted
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         ack_armed <= 1'b0;
      end else begin
         ack_armed <= !(&bus.proc_select_b) && !(ack_armed && ack_level);
      end
   end

   // Float request only for deadlock recovery, on user demand
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         bus.bus_float_request_b <= 1'b1;
      end else begin
         bus.bus_float_request_b <= !float_req_in;
      end
   end

   // Hold request until access completes; select exactly one processor once granted
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         bus.host_bus_request_b <= 1'b1;
         bus.proc_select_b      <= 4'hF;
         bus.addr               <= '0;
         bus.rd_b               <= 1'b1;
         bus.wr_b               <= 1'b1;
         access_done_out        <= 1'b0;
         bus_owned_out          <= 1'b0;
      end else begin
         access_done_out <= 1'b0;
         bus_owned_out   <= granted;
         if (access_req_in && bus.host_bus_request_b) begin
            bus.host_bus_request_b <= 1'b0;
         end else if (!bus.host_bus_request_b && granted && &bus.proc_select_b) begin
            bus.proc_select_b <= ~(4'h1 << proc_index_in);
            bus.addr          <= access_addr_in;
            bus.rd_b          <= access_write_in;
            bus.wr_b          <= !access_write_in;
         end else if (!(&bus.proc_select_b) && ack_armed && ack_level) begin
            bus.proc_select_b      <= 4'hF;
            bus.rd_b               <= 1'b1;
            bus.wr_b               <= 1'b1;
            bus.host_bus_request_b <= 1'b1;
            access_done_out        <= 1'b1;
         end
      end
   end
endmodule

// ==== tb/mp_bus_props.sv ====
// Concurrent checks on the interface between the host end and the processor end
`timescale 1ns/10ps
module mp_bus_props (
   input wire logic                         core_clk_in,
   input wire logic                         rst_b_in,
   input wire logic                         bus_float_request_b,
   input wire logic                         host_bus_request_b,
   input wire logic                         host_bus_grant_oe,
   input wire logic [mp_bus_pkg::SEL_W-1:0] proc_select_b,
   input wire logic                         host_wait_ack_out,
   input wire logic                         host_wait_ack_oe,
   input wire logic                         bus_drive_oe
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);
   // Line actually pulled low; push-pull high counts as released
   logic ack_low;
   assign ack_low = host_wait_ack_oe && !host_wait_ack_out;
   a_float_tristates: assert property (!bus_float_request_b |=> !bus_drive_oe)
      else $error("bus driven after float request");
   a_float_no_grant: assert property (!bus_float_request_b |=> !host_bus_grant_oe)
      else $error("grant given during float request");
   a_grant_prompt: assert property ($fell(host_bus_request_b) && bus_float_request_b
      |=> host_bus_grant_oe)
      else $error("grant late after host request");
   a_grant_only_requested: assert property (host_bus_grant_oe |-> !$past(host_bus_request_b))
      else $error("grant driven without host request");
   a_grant_held: assert property (host_bus_grant_oe && !host_bus_request_b
      && bus_float_request_b |=> host_bus_grant_oe)
      else $error("grant dropped while request held");
   a_grant_release: assert property (host_bus_request_b |=> !host_bus_grant_oe)
      else $error("grant kept after request release");
   a_yield_tristate: assert property (host_bus_grant_oe && !host_bus_request_b
      |=> !bus_drive_oe)
      else $error("bus driven while host owns it");
   a_ack_needs_sel: assert property (host_wait_ack_oe |-> !$past(host_bus_request_b)
      && $past(proc_select_b) != 4'hF)
      else $error("acknowledge driven without select and request");
   a_ack_wait_len: assert property ($rose(ack_low) |-> ack_low[*4] ##1 !ack_low)
      else $error("wait state length wrong");
endmodule

// ==== tb/shared_bus_host_arbitration_tb.sv ====
// Self-checking bench joining the processor end and the host end
`timescale 1ns/10ps
module shared_bus_host_arbitration_tb;
   typedef struct packed {
      logic       rot;
      logic [3:0] core;
      logic [3:0] dma;
      logic [1:0] ext;
      logic [3:0] grant;
      logic [2:0] id;
   } arb_row_t;
   // Row order matters: rotation starts after the previous master
   arb_row_t rows [6] = '{'{1'h0, 4'hA, 4'h0, 2'h0, 4'h2, 3'h2},
                          '{1'h0, 4'h8, 4'h1, 2'h0, 4'h8, 3'h4},
                          '{1'h0, 4'h0, 4'h6, 2'h0, 4'h2, 3'h2},
                          '{1'h0, 4'h1, 4'h0, 2'h0, 4'h1, 3'h1},
                          '{1'h1, 4'h3, 4'h0, 2'h0, 4'h2, 3'h2},
                          '{1'h0, 4'h4, 4'h0, 2'h1, 4'h4, 3'h3}};
   logic       core_clk, rst_b, rot_sel, acc_req, float_req, acc_done, owned;
   logic [3:0] core_req, dma_req, ack_mode, grant, stall;
   logic [1:0] ext_req, acc_idx;
   logic [5:0] req_drive;
   logic [2:0] master_id;
   int         miscompares, n_checks, hi_cnt;
   mp_bus_if bus_if ();
   // Open-drain and wired lines resolved here; unused request lines float high
   assign bus_if.host_bus_grant_b = !bus_if.host_bus_grant_oe;
   assign bus_if.core_priority_access_b = !bus_if.core_priority_access_oe;
   assign bus_if.mp_bus_request_b = ~(req_drive | {ext_req, 4'h0});
   mp_bus_device u_mp_bus_device (.core_clk_in(core_clk), .rst_b_in(rst_b), .bus(bus_if),
      .core_access_req_in(core_req), .dma_access_req_in(dma_req), .ack_drive_mode_in(ack_mode),
      .proc_id_base_in(3'h1), .rotating_priority_select_in(rot_sel), .host_access_done_in(1'h0),
      .access_grant_out(grant), .access_stall_out(stall), .mp_bus_request_drive_out(req_drive),
      .bus_master_id_out(master_id));
   mp_bus_host u_mp_bus_host (.core_clk_in(core_clk), .rst_b_in(rst_b), .bus(bus_if),
      .access_req_in(acc_req), .proc_index_in(acc_idx), .access_write_in(acc_idx[0]),
      .access_addr_in({30'h0, acc_idx}), .float_req_in(float_req),
      .access_done_out(acc_done), .bus_owned_out(owned));
   mp_bus_props u_mp_bus_props (.core_clk_in(core_clk), .rst_b_in(rst_b),
      .bus_float_request_b(bus_if.bus_float_request_b),
      .host_bus_request_b(bus_if.host_bus_request_b),
      .host_bus_grant_oe(bus_if.host_bus_grant_oe), .proc_select_b(bus_if.proc_select_b),
      .host_wait_ack_out(bus_if.host_wait_ack_out), .host_wait_ack_oe(bus_if.host_wait_ack_oe),
      .bus_drive_oe(bus_if.bus_drive_oe));
   initial begin
      core_clk = 1'h0;
      forever #2.5 core_clk = !core_clk;
   end
   // Push-pull mode is the only way the line may be driven high
   always @(posedge core_clk) begin
      if (bus_if.host_wait_ack_oe === 1'h1 && bus_if.host_wait_ack_out === 1'h1) hi_cnt++;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bounded wait; the compare afterwards reports a miss
   task automatic wait_grant(input logic [3:0] exp);
      for (int k = 0; k < 20 && grant !== exp; k++) @(negedge core_clk);
   endtask
   task automatic host_access(input logic [1:0] idx, input logic mode);
      logic g_seen;
      g_seen = 1'h0;
      ack_mode = {4{mode}};
      acc_idx = idx;
      acc_req = 1'h1;
      for (int k = 0; k < 40 && acc_done !== 1'h1; k++) begin
         @(negedge core_clk);
         if (bus_if.host_bus_grant_oe === 1'h1 && !g_seen) begin
            g_seen = 1'h1;
            @(negedge core_clk);
            chk(grant, 4'h0);
            chk(bus_if.bus_drive_oe, 1'h0);
            chk(owned, 1'h1);
            chk(bus_if.proc_select_b, {4'h0, ~(4'h1 << idx)});
            chk(bus_if.addr[7:0], {6'h0, idx});
            chk({bus_if.rd_b, bus_if.wr_b}, {6'h0, idx[0], !idx[0]});
            @(negedge core_clk);
            chk({bus_if.host_wait_ack_oe, bus_if.host_wait_ack_out}, 2'h2);
         end
      end
      chk(g_seen, 1'h1);
      chk(acc_done, 1'h1);
      acc_req = 1'h0;
      @(negedge core_clk);
      chk(bus_if.host_wait_ack_oe, 1'h0);
      chk(bus_if.host_bus_grant_oe, 1'h0);
   endtask
   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #30000;
      miscompares++;
      finish_test();
   end
   initial begin
      {rst_b, rot_sel, acc_req, float_req, acc_idx, ext_req} = '0;
      {core_req, dma_req, ack_mode, hi_cnt} = '0;
      repeat (2) @(negedge core_clk);
      chk(bus_if.host_bus_grant_oe, 1'h0);
      chk(req_drive, 6'h0);
      rst_b = 1'h1;
      // Table of arbitration cases, requests released between rows
      foreach (rows[i]) begin
         {rot_sel, core_req, dma_req, ext_req} = {rows[i].rot, rows[i].core, rows[i].dma,
                                                 rows[i].ext};
         wait_grant(rows[i].grant);
         chk(grant, rows[i].grant);
         chk(master_id, rows[i].id);
         chk(req_drive[5:4], 2'h0);
         {core_req, dma_req, ext_req} = '0;
         wait_grant(4'h0);
      end
      // Host takes the bus from a busy master, twice, in both drive modes
      core_req = 4'h8;
      wait_grant(4'h8);
      chk(bus_if.core_priority_access_b, 1'h0);
      host_access(2'h2, 1'h0);
      chk(hi_cnt != 0, 1'h0);
      wait_grant(4'h8);
      chk(grant, 4'h8);
      host_access(2'h1, 1'h1);
      chk(hi_cnt != 0, 1'h1);
      // Float request mid-ownership stalls the master until removed
      wait_grant(4'h8);
      float_req = 1'h1;
      repeat (3) @(negedge core_clk);
      chk(bus_if.bus_drive_oe, 1'h0);
      chk(stall[3], 1'h1);
      float_req = 1'h0;
      for (int k = 0; k < 10 && stall !== 4'h0; k++) @(negedge core_clk);
      chk(stall, 4'h0);
      core_req = 4'h0;
      finish_test();
   end
endmodule
